// ==== design/icl_ctrl.sv ====
// Contract
// - Replacement never picks a locked sector, even at the bottom.
// - Lock of a present sector marks that sector locked.
// - Lock miss replaces LRU unlocked sector: new tag, valids clear.
// - All sectors locked: lock miss allocates nothing, state kept.
// - Locked sector becomes MRU; present data, valids, tag untouched.
// - Cache disabled: lock, unlock, free, flush raise illegal.
// - Unlock allocates absent sector then clears lock; none if full.
// - Unlocked sector becomes MRU, contents kept.
// - Unlock-all clears every lock, nothing else changes.
// - Global flush: valids clear, tags ones, stack reset, unlocked.
// - Unlocked flush: only unlocked sectors cleared, stack reset.
// - Leaving cache mode flushes the cache automatically.
// - DMA never changes tags, valids or stack.
// - Cache disabled: array is plain memory for DMA and moves.
// - Cache enabled: DMA goes external, no coherency.
// - Move read hit returns array data, stack unchanged.
// - Move read miss reads external with waits, no state change.
// - Move write hit writes array and external, sets valid.
// - Move write miss writes only external, state unchanged.
// - Debug reads tags, locks, LRU and hit status serially.
// - Valid query in status bit 5; nine reads from tag 0.
// - Address splits into 7-bit offset and 17-bit tag.
// - Cache enable input clear disables, set enables.
`timescale 1ns/1ps
module icl_ctrl (
    input  wire logic                        mclk,
    input  wire logic                        srst,
    input  wire logic                        cache_en,
    input  wire logic                        cmd_valid,
    input  wire logic [2:0]                  cmd_op,
    input  wire logic [icl_pkg::ADDR_W-1:0]  cmd_addr,
    output logic                             cmd_done,
    output logic                             illegal_irq,
    input  wire logic                        pm_valid,
    input  wire logic                        pm_write,
    input  wire logic [icl_pkg::ADDR_W-1:0]  pm_addr,
    input  wire logic [icl_pkg::WORD_W-1:0]  pm_wdata,
    output logic [icl_pkg::WORD_W-1:0]       pm_rdata,
    output logic                             pm_done,
    output logic                             pm_busy,
    input  wire logic [icl_pkg::WAIT_W-1:0]  bus_wait_config,
    output logic                             ext_req,
    output logic                             ext_write,
    output logic [icl_pkg::ADDR_W-1:0]       ext_addr,
    output logic [icl_pkg::WORD_W-1:0]       ext_wdata,
    input  wire logic [icl_pkg::WORD_W-1:0]  ext_rdata,
    input  wire logic                        dma_valid,
    input  wire logic                        dma_write,
    input  wire logic [icl_pkg::MEM_W-1:0]   dma_addr,
    input  wire logic [icl_pkg::WORD_W-1:0]  dma_wdata,
    output logic [icl_pkg::WORD_W-1:0]       dma_rdata,
    output logic                             dma_ready,
    output logic                             dma_to_ext,
    input  wire logic                        debug_mode,
    input  wire logic                        dbg_rd,
    output logic [icl_pkg::WORD_W-1:0]       dbg_data,
    input  wire logic                        dbg_vq,
    input  wire logic [icl_pkg::ADDR_W-1:0]  dbg_vq_addr,
    output logic [7:0]                       dbg_status
);
    localparam int N = icl_pkg::SECT;
    localparam int TW = icl_pkg::TAG_W;
    localparam int OW = icl_pkg::OFF_W;
    localparam int SW = icl_pkg::SEC_W;
    localparam int AW = icl_pkg::ADDR_W;
    localparam int WW = icl_pkg::WORD_W;
    localparam int WT = icl_pkg::WAIT_W;

    typedef enum logic {PM_IDLE, PM_WAIT} icl_pm_st_t;

    logic [N-1:0][TW-1:0]      tag, next_tag;
    logic [N-1:0][(1<<OW)-1:0] valid, next_valid;
    logic [N-1:0]              lock, next_lock;
    logic [WW-1:0]             mem [1 << icl_pkg::MEM_W];
    logic                      ce_q, next_ce_q;
    logic                      auto_flush;
    logic [AW-1:0]             look_addr;
    logic [TW-1:0]             look_tag;
    logic [OW-1:0]             look_off;
    logic                      sec_hit;
    logic [SW-1:0]             hit_sec;
    logic                      word_ok;
    logic [SW-1:0]             victim;
    logic                      victim_ok;
    logic [SW-1:0]             lru_sec;
    logic                      touch;
    logic [SW-1:0]             touch_sec;
    logic                      lru_init;
    logic                      cmd_ok;
    logic                      pm_take;
    logic                      pm_set_valid;
    icl_pm_st_t                pm_st, next_pm_st;
    logic [WT:0]               wcnt, next_wcnt;
    logic [WW-1:0]             next_pm_rdata;
    logic                      next_pm_done;
    logic                      next_ext_req, next_ext_write;
    logic [AW-1:0]             next_ext_addr;
    logic [WW-1:0]             next_ext_wdata;
    logic                      pm_ext_rd, next_pm_ext_rd;
    logic                      mem_we;
    logic [icl_pkg::MEM_W-1:0] mem_a;
    logic [WW-1:0]             mem_wd;
    logic                      last_hit, next_last_hit;
    logic [3:0]                dbg_ptr, next_dbg_ptr;
    logic [WW-1:0]             next_dbg_data;
    logic [7:0]                next_dbg_status;
    logic                      next_cmd_done, next_illegal;

    assign cmd_ok = cmd_valid && cache_en;
    assign pm_take = pm_valid && pm_st == PM_IDLE && !cmd_valid;
    assign pm_busy = pm_st == PM_WAIT;
    assign auto_flush = ce_q && !cache_en;
    assign next_ce_q = cache_en;

    always_comb
    begin
        if (cmd_valid)
            look_addr = cmd_addr;
        else if (pm_valid)
            look_addr = pm_addr;
        else
            look_addr = dbg_vq_addr;
    end
    assign look_tag = look_addr[AW-1 -: TW];
    assign look_off = look_addr[OW-1:0];
    assign word_ok = sec_hit && valid[hit_sec][look_off];

    icl_match #(.N(N), .TW(TW), .SW(SW)) u_match (
        .tags    (tag),
        .tag_in  (look_tag),
        .hit     (sec_hit),
        .hit_sec (hit_sec)
    );

    icl_lru #(.N(N), .SW(SW)) u_lru (
        .mclk      (mclk),
        .srst      (srst),
        .touch     (touch),
        .touch_sec (touch_sec),
        .init      (lru_init),
        .lock      (lock),
        .victim    (victim),
        .victim_ok (victim_ok),
        .lru_sec   (lru_sec)
    );

    // Cache state: commands, auto flush, write-hit valid set
    always_comb
    begin
        next_tag = tag;
        next_valid = valid;
        next_lock = lock;
        touch = 1'b0;
        touch_sec = hit_sec;
        lru_init = 1'b0;
        if (auto_flush)
        begin
            next_tag = {N{icl_pkg::TAG_RST}};
            next_valid = '0;
            next_lock = '0;
            lru_init = 1'b1;
        end
        else if (cmd_ok)
        begin
            unique case (cmd_op)
                icl_pkg::OP_LOCK, icl_pkg::OP_UNLOCK:
                    if (sec_hit)
                    begin
                        next_lock[hit_sec] = cmd_op == icl_pkg::OP_LOCK;
                        touch = 1'b1;
                    end
                    else if (victim_ok)
                    begin
                        next_tag[victim] = look_tag;
                        next_valid[victim] = '0;
                        next_lock[victim] = cmd_op == icl_pkg::OP_LOCK;
                        touch = 1'b1;
                        touch_sec = victim;
                    end
                icl_pkg::OP_FREE:
                    next_lock = '0;
                icl_pkg::OP_FLUSH:
                begin
                    next_tag = {N{icl_pkg::TAG_RST}};
                    next_valid = '0;
                    next_lock = '0;
                    lru_init = 1'b1;
                end
                icl_pkg::OP_FLUSHUN:
                begin
                    for (int i = 0; i < N; i++)
                        if (!lock[i])
                        begin
                            next_tag[i] = icl_pkg::TAG_RST;
                            next_valid[i] = '0;
                        end
                    lru_init = 1'b1;
                end
                default: ;
            endcase
        end
        else if (pm_set_valid)
            next_valid[hit_sec][look_off] = 1'b1;
    end

    assign next_cmd_done = cmd_valid;
    assign next_illegal = cmd_valid && !cache_en;

    // Program-space moves and array port
    always_comb
    begin
        next_pm_st = pm_st;
        next_wcnt = wcnt;
        next_pm_rdata = pm_rdata;
        next_pm_done = 1'b0;
        next_ext_req = 1'b0;
        next_ext_write = ext_write;
        next_ext_addr = ext_addr;
        next_ext_wdata = ext_wdata;
        next_pm_ext_rd = pm_ext_rd;
        pm_set_valid = 1'b0;
        mem_we = 1'b0;
        mem_a = dma_addr;
        mem_wd = dma_wdata;
        dma_ready = !cache_en && !pm_take;
        unique case (pm_st)
            PM_IDLE:
                if (pm_take)
                begin
                    mem_a = !cache_en ? pm_addr[icl_pkg::MEM_W-1:0]
                                      : {hit_sec, look_off};
                    mem_wd = pm_wdata;
                    if (!cache_en)
                    begin
                        mem_we = pm_write;
                        next_pm_rdata = mem[mem_a];
                        next_pm_done = 1'b1;
                    end
                    else if (!pm_write && word_ok)
                    begin
                        next_pm_rdata = mem[mem_a];
                        next_pm_done = 1'b1;
                    end
                    else
                    begin
                        mem_we = pm_write && sec_hit;
                        pm_set_valid = pm_write && sec_hit;
                        next_ext_req = 1'b1;
                        next_ext_write = pm_write;
                        next_ext_addr = pm_addr;
                        next_ext_wdata = pm_wdata;
                        next_pm_ext_rd = !pm_write;
                        next_wcnt = {1'b0, bus_wait_config};
                        next_pm_st = PM_WAIT;
                    end
                end
                else if (dma_valid && !cache_en)
                    mem_we = dma_write;
            PM_WAIT:
            begin
                dma_ready = !cache_en;
                if (wcnt == '0)
                begin
                    if (pm_ext_rd)
                        next_pm_rdata = ext_rdata;
                    next_pm_done = 1'b1;
                    next_pm_st = PM_IDLE;
                end
                else
                    next_wcnt = wcnt - (WT+1)'(1);
                if (dma_valid && !cache_en)
                    mem_we = dma_write;
            end
        endcase
    end
    assign dma_to_ext = cache_en;

    // Debug readout: pointer walks tags 0..7 then status word
    always_comb
    begin
        next_dbg_ptr = dbg_ptr;
        next_dbg_data = dbg_data;
        next_dbg_status = dbg_status;
        next_last_hit = last_hit;
        if (pm_take && cache_en && !pm_write)
            next_last_hit = word_ok;
        if (debug_mode && dbg_rd)
        begin
            if (dbg_ptr == icl_pkg::DBG_LAST)
            begin
                next_dbg_data = '0;
                next_dbg_data[N-1:0] = lock;
                next_dbg_data[N +: SW] = lru_sec;
                next_dbg_data[N+SW] = last_hit;
                next_dbg_ptr = '0;
            end
            else
            begin
                next_dbg_data = WW'(tag[dbg_ptr[SW-1:0]]);
                next_dbg_ptr = dbg_ptr + 4'h1;
            end
        end
        if (!debug_mode)
            next_dbg_ptr = '0;
        if (debug_mode && dbg_vq && !cmd_valid && !pm_valid)
        begin
            next_dbg_status = '0;
            next_dbg_status[icl_pkg::DBG_VALID_BIT] = word_ok;
            next_dbg_status[icl_pkg::DBG_HIT_BIT] = sec_hit;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (mem_we)
            mem[mem_a] <= mem_wd;
        dma_rdata <= mem[dma_addr];
    end

    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            tag <= {N{icl_pkg::TAG_RST}};
            valid <= '0;
            lock <= '0;
            ce_q <= 1'b0;
            cmd_done <= 1'b0;
            illegal_irq <= 1'b0;
            pm_st <= PM_IDLE;
            wcnt <= '0;
            pm_rdata <= '0;
            pm_done <= 1'b0;
            ext_req <= 1'b0;
            ext_write <= 1'b0;
            ext_addr <= '0;
            ext_wdata <= '0;
            pm_ext_rd <= 1'b0;
            last_hit <= 1'b0;
            dbg_ptr <= '0;
            dbg_data <= '0;
            dbg_status <= '0;
        end
        else
        begin
            tag <= next_tag;
            valid <= next_valid;
            lock <= next_lock;
            ce_q <= next_ce_q;
            cmd_done <= next_cmd_done;
            illegal_irq <= next_illegal;
            pm_st <= next_pm_st;
            wcnt <= next_wcnt;
            pm_rdata <= next_pm_rdata;
            pm_done <= next_pm_done;
            ext_req <= next_ext_req;
            ext_write <= next_ext_write;
            ext_addr <= next_ext_addr;
            ext_wdata <= next_ext_wdata;
            pm_ext_rd <= next_pm_ext_rd;
            last_hit <= next_last_hit;
            dbg_ptr <= next_dbg_ptr;
            dbg_data <= next_dbg_data;
            dbg_status <= next_dbg_status;
        end
    end

    logic op_lk;
    logic op_miss;
    assign op_lk = cmd_ok && !auto_flush && cmd_op == icl_pkg::OP_LOCK;
    assign op_miss = op_lk && !sec_hit;

    property p_victim_unlocked;
        @(posedge mclk) disable iff (srst)
        op_miss && victim_ok |-> !lock[victim];
    endproperty
    a_victim_unlocked: assert property (p_victim_unlocked)
        else $error("locked sector chosen as victim");

    property p_lock_hit;
        @(posedge mclk) disable iff (srst)
        op_lk && sec_hit |=> lock[$past(hit_sec)]
            && tag == $past(tag) && valid == $past(valid);
    endproperty
    a_lock_hit: assert property (p_lock_hit)
        else $error("lock hit did not lock sector");

    property p_lock_alloc;
        @(posedge mclk) disable iff (srst)
        op_miss && victim_ok |=> lock[$past(victim)]
            && tag[$past(victim)] == $past(look_tag)
            && valid[$past(victim)] == '0;
    endproperty
    a_lock_alloc: assert property (p_lock_alloc)
        else $error("lock miss allocation wrong");

    property p_lock_full;
        @(posedge mclk) disable iff (srst)
        op_miss && !victim_ok |=> tag == $past(tag)
            && valid == $past(valid) && lock == $past(lock);
    endproperty
    a_lock_full: assert property (p_lock_full)
        else $error("full cache changed on lock");

    property p_illegal;
        @(posedge mclk) disable iff (srst)
        cmd_valid && !cache_en && !auto_flush
            |=> illegal_irq && cmd_done && tag == $past(tag);
    endproperty
    a_illegal: assert property (p_illegal)
        else $error("disabled command not illegal");

    property p_free;
        @(posedge mclk) disable iff (srst)
        cmd_ok && !auto_flush && cmd_op == icl_pkg::OP_FREE
            |=> lock == '0 && tag == $past(tag) && valid == $past(valid);
    endproperty
    a_free: assert property (p_free)
        else $error("unlock all wrong");

    property p_flush;
        @(posedge mclk) disable iff (srst)
        (cmd_ok && cmd_op == icl_pkg::OP_FLUSH) || auto_flush
            |=> valid == '0 && lock == '0
            && tag == {N{icl_pkg::TAG_RST}} && lru_sec == SW'(N - 1);
    endproperty
    a_flush: assert property (p_flush)
        else $error("global flush incomplete");

    property p_flushun;
        @(posedge mclk) disable iff (srst)
        cmd_ok && !auto_flush && cmd_op == icl_pkg::OP_FLUSHUN
            |=> lock == $past(lock);
    endproperty
    a_flushun: assert property (p_flushun)
        else $error("unlocked flush changed locks");

    property p_rd_miss;
        @(posedge mclk) disable iff (srst)
        pm_take && cache_en && !pm_write && !word_ok
            |=> ext_req ##[0:16] pm_done;
    endproperty
    a_rd_miss: assert property (p_rd_miss)
        else $error("read miss not completed");

    property p_dbg_wrap;
        @(posedge mclk) disable iff (srst)
        debug_mode && dbg_rd && dbg_ptr == icl_pkg::DBG_LAST
            |=> dbg_ptr == '0;
    endproperty
    a_dbg_wrap: assert property (p_dbg_wrap)
        else $error("debug pointer did not wrap");

    c_lock_alloc: cover property (@(posedge mclk) op_miss && victim_ok);
    c_rd_miss: cover property (@(posedge mclk) pm_busy ##1 pm_done);
    c_auto_flush: cover property (@(posedge mclk) auto_flush);
endmodule

// ==== design/icl_pkg.sv ====
package icl_pkg;
    localparam int ADDR_W = 24;
    localparam int WORD_W = 24;
    localparam int TAG_W = 17;
    localparam int OFF_W = 7;
    localparam int SECT = 8;
    localparam int SEC_W = 3;
    localparam int MEM_W = SEC_W + OFF_W;
    localparam int WAIT_W = 4;
    localparam logic [TAG_W-1:0] TAG_RST = 17'h1FFFF;
    localparam int DBG_REGS = 9;
    localparam logic [3:0] DBG_LAST = 4'h8;
    localparam int DBG_VALID_BIT = 5;
    localparam int DBG_HIT_BIT = 0;
    // Software spacing after a cache enable change, in instruction cycles
    localparam int CE_GAP_CYC = 3;
    typedef enum logic [2:0] {
        OP_LOCK    = 3'h0,
        OP_UNLOCK  = 3'h1,
        OP_FREE    = 3'h2,
        OP_FLUSH   = 3'h3,
        OP_FLUSHUN = 3'h4
    } icl_op_t;
endpackage

// ==== design/icl_match.sv ====
`timescale 1ns/1ps
module icl_match #(
    parameter int N = 8,
    parameter int TW = 17,
    parameter int SW = 3
) (
    input  wire logic [N-1:0][TW-1:0] tags,
    input  wire logic [TW-1:0]        tag_in,
    output logic                      hit,
    output logic [SW-1:0]             hit_sec
);
    logic [N-1:0] eq;

    if (N > (1 << SW)) $error("icl_match: N too large for SW");

    for (genvar g = 0; g < N; g++)
    begin : g_cmp
        assign eq[g] = (tags[g] == tag_in);
    end

    always_comb
    begin
        hit = |eq;
        hit_sec = '0;
        for (int i = N - 1; i >= 0; i--)
            if (eq[i])
                hit_sec = SW'(i);
    end
endmodule

// ==== design/icl_lru.sv ====
`timescale 1ns/1ps
module icl_lru #(
    parameter int N = 8,
    parameter int SW = 3
) (
    input  wire logic          mclk,
    input  wire logic          srst,
    input  wire logic          touch,
    input  wire logic [SW-1:0] touch_sec,
    input  wire logic          init,
    input  wire logic [N-1:0]  lock,
    output logic [SW-1:0]      victim,
    output logic               victim_ok,
    output logic [SW-1:0]      lru_sec
);
    logic [SW-1:0] stack [N];
    logic [SW-1:0] next_stack [N];
    int pos;

    if (N < 2 || N > (1 << SW)) $error("icl_lru: bad N");

    always_comb
    begin
        pos = N - 1;
        for (int i = N - 1; i >= 0; i--)
            if (stack[i] == touch_sec)
                pos = i;
        for (int i = 0; i < N; i++)
            next_stack[i] = stack[i];
        if (init)
            for (int i = 0; i < N; i++)
                next_stack[i] = SW'(i);
        else if (touch)
        begin
            next_stack[0] = touch_sec;
            for (int i = 1; i < N; i++)
                if (i <= pos)
                    next_stack[i] = stack[i-1];
        end
    end

    // Deepest unlocked entry wins; locked ones are skipped
    always_comb
    begin
        victim = stack[N-1];
        victim_ok = 1'b0;
        for (int i = 0; i < N; i++)
            if (!lock[stack[i]])
            begin
                victim = stack[i];
                victim_ok = 1'b1;
            end
    end

    assign lru_sec = stack[N-1];

    always_ff @(posedge mclk)
        for (int i = 0; i < N; i++)
            stack[i] <= srst ? SW'(i) : next_stack[i];
endmodule

// ==== dv/icl_ext_mem.sv ====
`timescale 1ns/1ps
module icl_ext_mem (
    input  wire logic        mclk,
    input  wire logic        ext_req,
    input  wire logic        ext_write,
    input  wire logic [23:0] ext_addr,
    input  wire logic [23:0] ext_wdata,
    input  wire logic [3:0]  bus_wait_config,
    output logic [23:0]      ext_rdata
);
    logic [23:0] mem [16];
    int          cnt = 0;
    always @(posedge mclk)
    begin
        if (ext_req)
        begin
            if (ext_write)
                mem[ext_addr[3:0]] <= ext_wdata;
            cnt <= int'(bus_wait_config) + 2;
        end
        else if (cnt > 0)
            cnt <= cnt - 1;
    end
    // Inverted data outside an access window
    assign ext_rdata = (cnt > 0) ? mem[ext_addr[3:0]] : ~mem[ext_addr[3:0]];
endmodule

// ==== dv/icl_ctrl_tb.sv ====
`timescale 1ns/1ps
module icl_ctrl_tb;
    typedef struct packed {logic en; logic [2:0] op; logic irq;} icl_row_t;
    logic        mclk = 1'h0;
    logic        srst = 1'h1;
    logic        cache_en = 1'h0;
    logic        cmd_valid = 1'h0;
    logic [2:0]  cmd_op = 3'h0;
    logic [23:0] cmd_addr = 24'h0;
    logic        pm_valid = 1'h0;
    logic        pm_write = 1'h0;
    logic [23:0] pm_addr = 24'h0;
    logic [23:0] pm_wdata = 24'h0;
    logic [3:0]  bus_wait_config = 4'h2;
    logic        dma_valid = 1'h0;
    logic        dma_write = 1'h0;
    logic [9:0]  dma_addr = 10'h005;
    logic [23:0] dma_wdata = 24'h0;
    logic        debug_mode = 1'h0;
    logic        dbg_rd = 1'h0;
    logic        dbg_vq = 1'h0;
    logic [23:0] dbg_vq_addr = 24'h0;
    logic        cmd_done, illegal_irq, pm_done, pm_busy, ext_req, ext_write;
    logic        dma_ready, dma_to_ext;
    logic [23:0] pm_rdata, ext_addr, ext_wdata, ext_rdata, dma_rdata, dbg_data;
    logic [7:0]  dbg_status;
    logic [16:0] et [8];
    logic [7:0]  el;
    logic        eh = 1'h0;
    int          errors = 0;
    int          checks = 0;
    int          cyc = 0;
    int          n;
    icl_row_t    rows [8] = '{5'h01, 5'h03, 5'h05, 5'h07, 5'h09,
                              5'h14, 5'h18, 5'h16};

    icl_ctrl u_icl_ctrl (.*);
    icl_ext_mem u_icl_ext_mem (.*);

    always #2.5 mclk = ~mclk;

    task automatic summarize;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    always @(posedge mclk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            errors++;
            summarize;
        end
    end

    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        checks++;
        if (got !== exp)
        begin
            errors++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic set_en(input logic v);
        @(posedge mclk);
        cache_en <= v;
        repeat (4) @(posedge mclk);
    endtask

    task automatic cmd(input logic [2:0] op, input logic [16:0] tg,
                       input logic irq);
        @(posedge mclk);
        cmd_valid <= 1'h1;
        cmd_op <= op;
        cmd_addr <= {tg, 7'h05};
        @(posedge mclk);
        cmd_valid <= 1'h0;
        #1;
        chk(24'(cmd_done), 24'h1);
        chk(24'(illegal_irq), 24'(irq));
    endtask

    task automatic dump(input logic [2:0] lru);
        for (int i = 0; i < 9; i++)
        begin
            @(posedge mclk);
            dbg_rd <= 1'h1;
            @(posedge mclk);
            dbg_rd <= 1'h0;
            #1;
            if (i < 8)
                chk(dbg_data, 24'(et[i]));
            else
                chk(dbg_data, 24'({eh, lru, el}));
        end
    endtask

    task automatic vq(input logic [6:0] off, input logic [7:0] ex);
        @(posedge mclk);
        dbg_vq <= 1'h1;
        dbg_vq_addr <= {17'h30, off};
        @(posedge mclk);
        dbg_vq <= 1'h0;
        #1;
        chk(24'(dbg_status), 24'(ex));
    endtask

    task automatic pm(input logic wr, input logic [16:0] tg,
                      input logic [23:0] d, input int exp_n);
        @(posedge mclk);
        pm_valid <= 1'h1;
        pm_write <= wr;
        pm_addr <= {tg, 7'h05};
        pm_wdata <= d;
        @(posedge mclk);
        pm_valid <= 1'h0;
        n = 0;
        #1;
        while (pm_done !== 1'h1 && n < 20)
        begin
            chk(24'(pm_busy), 24'h1);
            @(posedge mclk);
            #1;
            n++;
        end
        chk(24'(n), 24'(exp_n));
        if (!wr)
            chk(pm_rdata, d);
    endtask

    initial
    begin
        repeat (20) @(posedge mclk);
        srst <= 1'h0;
        debug_mode <= 1'h1;
        foreach (et[i]) et[i] = 17'h1FFFF;
        el = 8'h00;
        dump(3'h7);
        $display("test reset done");
        @(posedge mclk);
        dma_valid <= 1'h1;
        dma_write <= 1'h1;
        dma_wdata <= 24'h5A5A5A;
        @(posedge mclk);
        dma_valid <= 1'h0;
        repeat (2) @(posedge mclk);
        #1;
        chk(dma_rdata, 24'h5A5A5A);
        chk(24'(dma_ready), 24'h1);
        chk(24'(dma_to_ext), 24'h0);
        pm(1'h0, 17'h0, 24'h5A5A5A, 0);
        foreach (rows[i])
        begin
            if (cache_en !== rows[i].en)
                set_en(rows[i].en);
            cmd(rows[i].op, 17'h0, rows[i].irq);
        end
        chk(24'(dma_to_ext), 24'h1);
        $display("test opcodes done");
        for (int k = 1; k < 8; k++)
        begin
            cmd(3'h0, 17'(k), 1'h0);
            et[8-k] = 17'(k);
        end
        el = 8'hFE;
        dump(3'h0);
        cmd(3'h1, 17'h1, 1'h0);
        cmd(3'h0, 17'h14, 1'h0);
        cmd(3'h0, 17'h15, 1'h0);
        et[0] = 17'h14;
        et[7] = 17'h15;
        el = 8'hFF;
        dump(3'h6);
        cmd(3'h0, 17'h16, 1'h0);
        cmd(3'h1, 17'h16, 1'h0);
        dump(3'h6);
        cmd(3'h2, 17'h0, 1'h0);
        el = 8'h00;
        dump(3'h6);
        cmd(3'h0, 17'h3, 1'h0);
        cmd(3'h4, 17'h0, 1'h0);
        foreach (et[i]) if (i != 5) et[i] = 17'h1FFFF;
        el = 8'h20;
        dump(3'h7);
        cmd(3'h3, 17'h0, 1'h0);
        et[5] = 17'h1FFFF;
        el = 8'h00;
        dump(3'h7);
        $display("test locking done");
        pm(1'h1, 17'h30, 24'h123456, 3);
        pm(1'h0, 17'h30, 24'h123456, 3);
        cmd(3'h0, 17'h30, 1'h0);
        pm(1'h1, 17'h30, 24'h654321, 3);
        @(posedge mclk);
        dma_valid <= 1'h1;
        dma_addr <= 10'h385;
        dma_wdata <= 24'hFFFFFF;
        @(posedge mclk);
        dma_valid <= 1'h0;
        #1;
        chk(24'(dma_ready), 24'h0);
        pm(1'h0, 17'h30, 24'h654321, 0);
        eh = 1'h1;
        vq(7'h05, 8'h21);
        vq(7'h06, 8'h01);
        set_en(1'h0);
        set_en(1'h1);
        dump(3'h7);
        pm(1'h0, 17'h30, 24'h654321, 3);
        $display("test moves done");
        summarize;
    end
endmodule
